// ===== design/flash_self_programming_sequencer.sv
// Flash self-programming sequencer with a classic Wishbone register slave.
//
// Contract
// R1 - Fuse 1 selects reset address 0x0000; fuse 0 selects the boot reset address.
// R2 - The core can never change fuse values; fuses come only from pins.
// R3 - Store operations take their flash address from the 16-bit pointer register.
// R4 - Low word-address bits pick the word in a page; high bits pick the page.
// R5 - The page address is latched at start; the pointer may then change freely.
// R6 - Lock-bit programming ignores the pointer entirely; the code refuses lock-bit patterns instead.
// R7 - Loads address flash by byte; pointer bit 0 selects the byte in a word.
// R8 - Erase pattern X0000011 then store within four cycles; only the page index matters.
// R9 - Erase of a readable-section page keeps running; a halting-section page halts the core.
// R10 - Load pattern X0000001 then store writes the data pair to the selected buffer word.
// R11 - The page buffer clears after page write, on section re-enable, and on reset.
// R12 - Software writes each buffer word at most once between buffer clears.
// R13 - Buffer words may be loaded in any order.
// R14 - Write pattern X0000101 then store programs the buffered page at the page index.
// R15 - Write of a readable-section page keeps running; a halting-section page halts the core.
// R16 - Software gives erase and write of one update the same page index.
// R17 - Software erases a page before writing it; buffer fill may come before or after.
// R18 - Software checks PLL lock before any programming step.
// R19 - With interrupt enabled, the interrupt stands while the store enable bit is clear.
// R20 - Software should program the boot section write lock when the loader is final; the code refuses the lock-bit pattern.
// R21 - Programming stores are accepted only from code running in the boot section.
// R22 - Section busy reads one while the readable section is blocked by erase or write.
// R23 - Control register clears six cycles after a write if no matching store follows.
// R24 - Each erase or write lasts between 3.7 ms and 4.5 ms.
// R25 - Store enable clears when erase, write or buffer load completes.
`timescale 1ns/100ps
module flash_self_programming_sequencer
  import seq_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_MIN_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Core status and control.
  input wire logic cpu_in_boot,
  output logic core_halt,
  output logic store_irq,
  output logic [15:0] reset_vector,
  output logic reset_vector_valid,
  // Pins.
  input wire logic boot_vector_fuse,
  input wire logic pll_locked,
  // Flash macro.
  output flash_cmd_t flash_cmd,
  input wire logic [`PAGE_WORD_BITS-1:0] flash_buf_idx,
  output logic [15:0] flash_buf_word,
  output logic [14:0] flash_rd_addr,
  input wire logic [15:0] flash_rd_data
);
  import seq_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    hit = (adr[7:2] == reg_adr[7:2]);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = old;
    for (int i = 0; i < 2; i++) begin
      if (sel[i]) begin
        merge16[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic legal_pattern(input logic [5:0] pat);
    // Lock-bit and signature patterns are refused, so the pointer never reaches them. [R6]
    legal_pattern = (pat == `PAT_LOAD) || (pat == `PAT_ERASE) ||
                    (pat == `PAT_WRITE) || (pat == `PAT_REEN);
  endfunction

  seq_state_t s_reg;
  seq_state_t s_next;
  logic tmr_done;
  logic wr_take;
  logic rd_take;
  logic store_ok;
  logic [`PAGE_IDX_BITS-1:0] ptr_page;

  // ************************************************************
  // Submodules
  // ************************************************************

  page_buffer u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(s_reg.buf_we),
    .wr_idx(s_reg.ptr[`PAGE_WORD_BITS:1]),
    .wr_data(s_reg.data),
    .clr(s_reg.buf_clr),
    .rd_idx(flash_buf_idx),
    .rd_data(flash_buf_word)
  );

  prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(s_reg.tmr_start),
    .done(tmr_done)
  );

  // ************************************************************
  // Next state
  // ************************************************************

  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
  assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;
  assign store_ok = s_reg.win_act && (s_reg.win < `STORE_WINDOW) &&
                    cpu_in_boot && (s_reg.op == OP_IDLE); // [R8] [R21]
  assign ptr_page = s_reg.ptr[15:`PAGE_WORD_BITS+1]; // [R3] [R4]

  always_comb begin
    s_next = s_reg;
    s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.buf_we = 1'b0;
    s_next.buf_clr = 1'b0;
    s_next.tmr_start = 1'b0;

    // Pins pass two flip-flops; the fuse is only ever read, never written. [R2]
    s_next.fuse_s1 = boot_vector_fuse;
    s_next.fuse_s2 = s_reg.fuse_s1;
    s_next.pll_s1 = pll_locked;
    s_next.pll_s2 = s_reg.pll_s1;
    s_next.fill = {s_reg.fill[0], 1'b1};
    if (s_reg.fill[1]) begin
      s_next.rst_vec = s_reg.fuse_s2 ? `APP_RESET_ADDR : `BOOT_RESET_ADDR; // [R1]
      s_next.vec_valid = 1'b1;
    end

    // Command window after a control write.
    if (s_reg.win_act) begin
      s_next.win = s_reg.win + 3'h1;
      if (s_reg.win == `CLEAR_DELAY - 3'h1) begin
        s_next.cs[`CS_CMD_MSB:0] = `PAT_NONE; // [R23]
        s_next.win_act = 1'b0;
      end
    end

    // Byte select one cycle after the flash read address goes out.
    if (s_reg.load_pend) begin
      s_next.load_byte = s_reg.load_sel ? flash_rd_data[15:8] : flash_rd_data[7:0]; // [R7]
      s_next.load_pend = 1'b0;
    end

    // End of erase or write.
    if (s_reg.op == OP_BUSY && tmr_done) begin
      s_next.op = OP_IDLE;
      s_next.cs[`CS_CMD_MSB:0] = `PAT_NONE; // [R25]
      s_next.halt = 1'b0;
      s_next.cmd.req = 1'b0;
      s_next.buf_clr = s_reg.op_write; // [R11]
    end

    if (wr_take) begin
      if (hit(wb_adr_i, `ADDR_CTRL) && wb_sel_i[0]) begin
        s_next.cs[`CS_IE] = wb_dat_i[`CS_IE];
        // Command bits are locked while any of them is still set.
        if (s_reg.cs[`CS_CMD_MSB:0] == `PAT_NONE && legal_pattern(wb_dat_i[5:0])) begin
          s_next.cs[`CS_CMD_MSB:0] = wb_dat_i[5:0];
          s_next.win = 3'h0;
          s_next.win_act = 1'b1;
        end
      end else if (hit(wb_adr_i, `ADDR_PTR)) begin
        s_next.ptr = merge16(s_reg.ptr, wb_dat_i, wb_sel_i);
      end else if (hit(wb_adr_i, `ADDR_DATA)) begin
        s_next.data = merge16(s_reg.data, wb_dat_i, wb_sel_i);
      end else if (hit(wb_adr_i, `ADDR_STORE) && store_ok) begin
        case (s_reg.cs[`CS_CMD_MSB:0])
          `PAT_LOAD: begin
            s_next.buf_we = 1'b1; // [R10]
            s_next.cs[`CS_CMD_MSB:0] = `PAT_NONE; // [R25]
            s_next.win_act = 1'b0;
          end
          `PAT_ERASE, `PAT_WRITE: begin
            // Data pair and in-page bits are ignored; only the page is latched.
            s_next.page = ptr_page; // [R5] [R8] [R14]
            s_next.op = OP_BUSY;
            s_next.op_write = (s_reg.cs[`CS_CMD_MSB:0] == `PAT_WRITE);
            s_next.tmr_start = 1'b1;
            s_next.halt = (ptr_page >= `HALTING_SECTION_FIRST_PAGE); // [R9] [R15]
            s_next.cs[`CS_BUSY] = (ptr_page < `HALTING_SECTION_FIRST_PAGE); // [R22]
            s_next.cmd.req = 1'b1;
            s_next.cmd.erase = (s_reg.cs[`CS_CMD_MSB:0] == `PAT_ERASE);
            s_next.cmd.page = ptr_page;
            s_next.win_act = 1'b0;
          end
          `PAT_REEN: begin
            s_next.cs[`CS_BUSY] = 1'b0;
            s_next.buf_clr = 1'b1; // [R11]
            s_next.cs[`CS_CMD_MSB:0] = `PAT_NONE;
            s_next.win_act = 1'b0;
          end
          default: begin
            s_next.win_act = s_next.win_act;
          end
        endcase
      end else if (hit(wb_adr_i, `ADDR_LOAD)) begin
        s_next.rd_addr = s_reg.ptr[15:1];
        s_next.load_sel = s_reg.ptr[0]; // [R7]
        s_next.load_pend = 1'b1;
      end
    end

    if (rd_take) begin
      if (hit(wb_adr_i, `ADDR_CTRL)) begin
        s_next.rdata = {24'h000000, s_reg.cs};
      end else if (hit(wb_adr_i, `ADDR_PTR)) begin
        s_next.rdata = {16'h0000, s_reg.ptr};
      end else if (hit(wb_adr_i, `ADDR_DATA)) begin
        s_next.rdata = {16'h0000, s_reg.data};
      end else if (hit(wb_adr_i, `ADDR_LOAD)) begin
        s_next.rdata = {24'h000000, s_reg.load_byte};
      end else if (hit(wb_adr_i, `ADDR_STAT)) begin
        // Software polls PLL lock here before programming.
        s_next.rdata = {s_reg.rst_vec, 12'h000, s_reg.halt, s_reg.op == OP_BUSY,
                        s_reg.vec_valid, s_reg.pll_s2};
      end else begin
        s_next.rdata = 32'h00000000;
      end
    end

    // Level interrupt follows the store enable bit, so it needs no clearing. [R19]
    s_next.irq = s_next.cs[`CS_IE] && !s_next.cs[`CS_EN];
  end

  // ************************************************************
  // State register
  // ************************************************************

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign core_halt = s_reg.halt;
  assign store_irq = s_reg.irq;
  assign reset_vector = s_reg.rst_vec;
  assign reset_vector_valid = s_reg.vec_valid;
  assign flash_cmd = s_reg.cmd;
  assign flash_rd_addr = s_reg.rd_addr;

  // ************************************************************
  // Assertions
  // ************************************************************

  int busy_cnt;
  localparam int MAX_CYCLES = `PROG_MAX_CYCLES;

  // Counts cycles of one operation to check its length.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt <= 0;
    end else if (s_reg.op == OP_BUSY) begin
      busy_cnt <= busy_cnt + 1;
    end else begin
      busy_cnt <= 0;
    end
  end

  property p_vector;
    @(posedge clk) disable iff (sys_rst)
    s_reg.vec_valid && $stable(s_reg.fuse_s2) |=>
      (reset_vector == ($past(s_reg.fuse_s2) ? `APP_RESET_ADDR : `BOOT_RESET_ADDR));
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector disagrees with fuse"); // [R1]

  property p_store_window;
    @(posedge clk) disable iff (sys_rst)
    $rose(s_reg.op == OP_BUSY) |-> $past(s_reg.win) < `STORE_WINDOW && $past(s_reg.win_act);
  endproperty
  a_store_window: assert property (p_store_window) else $error("store outside window"); // [R8]

  property p_boot_only;
    @(posedge clk) disable iff (sys_rst)
    $rose(s_reg.op == OP_BUSY) || s_reg.buf_we |-> $past(cpu_in_boot);
  endproperty
  a_boot_only: assert property (p_boot_only) else $error("store taken outside boot code"); // [R21]

  property p_halt_halting_section;
    @(posedge clk) disable iff (sys_rst)
    s_reg.op == OP_BUSY && s_reg.page >= `HALTING_SECTION_FIRST_PAGE |-> core_halt && !s_reg.cs[`CS_BUSY];
  endproperty
  a_halt_halting_section: assert property (p_halt_halting_section) else $error("core not halted"); // [R9]

  property p_run_rww;
    @(posedge clk) disable iff (sys_rst)
    s_reg.op == OP_BUSY && s_reg.page < `HALTING_SECTION_FIRST_PAGE |-> !core_halt && s_reg.cs[`CS_BUSY];
  endproperty
  a_run_rww: assert property (p_run_rww) else $error("readable section op wrong"); // [R15]

  property p_page_latched;
    @(posedge clk) disable iff (sys_rst)
    s_reg.op == OP_BUSY && $past(s_reg.op == OP_BUSY) |-> $stable(flash_cmd.page);
  endproperty
  a_page_latched: assert property (p_page_latched) else $error("page moved"); // [R5]

  property p_irq;
    @(posedge clk) disable iff (sys_rst)
    store_irq == (s_reg.cs[`CS_IE] && !s_reg.cs[`CS_EN]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong"); // [R19]

  property p_timeout;
    @(posedge clk) disable iff (sys_rst)
    s_reg.win_act && s_reg.win == 3'h5 |=>
      s_reg.cs[`CS_CMD_MSB:0] == `PAT_NONE || s_reg.op == OP_BUSY;
  endproperty
  a_timeout: assert property (p_timeout) else $error("control not cleared"); // [R23]

  property p_prog_time;
    @(posedge clk) disable iff (sys_rst)
    $fell(s_reg.op == OP_BUSY) |-> busy_cnt >= PROG_CYCLES && busy_cnt <= MAX_CYCLES;
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("programming time out of range"); // [R24]

  property p_done_clears;
    @(posedge clk) disable iff (sys_rst)
    $fell(s_reg.op == OP_BUSY) |-> !s_reg.cs[`CS_EN] && !core_halt ##1 !flash_cmd.req;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("enable not cleared"); // [R25]

  property p_ack;
    @(posedge clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");

  c_erase: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(s_reg.op == OP_BUSY) && flash_cmd.erase);
  c_write_halting_section: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(core_halt));
  c_load: cover property (@(posedge clk) disable iff (sys_rst) s_reg.buf_we);
  c_timeout: cover property (@(posedge clk) disable iff (sys_rst)
    s_reg.win_act && s_reg.win == 3'h5);
endmodule

// ===== design/page_buffer.sv
// Temporary page buffer: one word per page slot, loaded in any order.
`timescale 1ns/100ps
module page_buffer
  import seq_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Load and clear from the sequencer.
  input wire logic wr_en,
  input wire logic [`PAGE_WORD_BITS-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic clr,
  // Read port for the flash macro.
  input wire logic [`PAGE_WORD_BITS-1:0] rd_idx,
  output logic [15:0] rd_data
);
  import seq_pkg::*;

  logic [15:0] mem [`PAGE_WORDS];
  buf_state_t s_reg;
  buf_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = s_reg.filled[rd_idx] ? mem[rd_idx] : `ERASED_WORD;
    if (clr) begin
      s_next.filled = '0;
    end else if (wr_en && !s_reg.filled[wr_idx]) begin
      s_next.filled[wr_idx] = 1'b1; // [R13]
    end
  end

  // A second load to a filled slot is dropped; the slot keeps its first word. [R12]
  always_ff @(posedge clk) begin
    if (wr_en && !clr && !s_reg.filled[wr_idx]) begin
      mem[wr_idx] <= wr_data; // [R10]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0; // [R11]
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
endmodule

// ===== design/prog_timer.sv
// Programming-time counter for page erase and page write.
`timescale 1ns/100ps
module prog_timer
  import seq_pkg::*;
#(
  parameter int CYCLES = `PROG_MIN_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Start pulse in, done pulse out.
  input wire logic start,
  output logic done
);
  import seq_pkg::*;

  timer_state_t s_reg;
  timer_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.run = 1'b1;
      s_next.cnt = '0;
    end else if (s_reg.run) begin
      if (s_reg.cnt == `TIMER_BITS'(CYCLES - 1)) begin
        s_next.run = 1'b0;
        s_next.done = 1'b1; // [R24]
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
endmodule

// ===== design/seq_map.svh
// Address map, field positions, command patterns and timing for the flash store sequencer.
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// Register byte addresses on the bus.
`define ADDR_CTRL 8'h00
`define ADDR_PTR 8'h04
`define ADDR_DATA 8'h08
`define ADDR_STORE 8'h0c
`define ADDR_LOAD 8'h10
`define ADDR_STAT 8'h14

// Bit positions in store_ctrl_status.
`define CS_EN 0
`define CS_BUSY 6
`define CS_IE 7
`define CS_CMD_MSB 5

// Accepted command patterns in the low six bits.
`define PAT_NONE 6'h00
`define PAT_LOAD 6'h01
`define PAT_ERASE 6'h03
`define PAT_WRITE 6'h05
`define PAT_REEN 6'h11

// Cycle windows after a control write.
`define STORE_WINDOW 3'h4
`define CLEAR_DELAY 3'h6

// Flash geometry and reset addresses.
`define PAGE_WORD_BITS 6
`define PAGE_IDX_BITS 9
`define PAGE_WORDS 64
`define HALTING_SECTION_FIRST_PAGE 9'h1c0
`define APP_RESET_ADDR 16'h0000
`define BOOT_RESET_ADDR 16'h7c00
`define ERASED_WORD 16'hffff

// Programming time, in nanoseconds, and the clock period.
`define CLK_PERIOD_NS 10
`define PROG_MIN_NS 3700000
`define PROG_MAX_NS 4500000
`define PROG_MIN_CYCLES ((`PROG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_MAX_CYCLES (`PROG_MAX_NS / `CLK_PERIOD_NS)
`define TIMER_BITS 19

`endif

// ===== design/seq_pkg.sv
// Types shared by the flash store sequencer and its helpers.
package seq_pkg;
  `include "seq_map.svh"

  typedef enum logic {OP_IDLE, OP_BUSY} op_state_t;

  typedef struct packed {
    logic req;
    logic erase;
    logic [`PAGE_IDX_BITS-1:0] page;
  } flash_cmd_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] cs;
    logic [15:0] ptr;
    logic [15:0] data;
    logic win_act;
    logic [2:0] win;
    op_state_t op;
    logic op_write;
    logic [`PAGE_IDX_BITS-1:0] page;
    logic halt;
    logic irq;
    flash_cmd_t cmd;
    logic [14:0] rd_addr;
    logic load_pend;
    logic load_sel;
    logic [7:0] load_byte;
    logic fuse_s1;
    logic fuse_s2;
    logic pll_s1;
    logic pll_s2;
    logic [1:0] fill;
    logic vec_valid;
    logic [15:0] rst_vec;
    logic buf_we;
    logic buf_clr;
    logic tmr_start;
  } seq_state_t;

  typedef struct packed {
    logic [`PAGE_WORDS-1:0] filled;
    logic [15:0] rdata;
  } buf_state_t;

  typedef struct packed {
    logic run;
    logic done;
    logic [`TIMER_BITS-1:0] cnt;
  } timer_state_t;
endpackage

// ===== tb/flash_model.sv
// Behavioural flash array serving page erase, page write and word reads.
`timescale 1ns/100ps
module flash_model
  import seq_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side.
  input wire flash_cmd_t flash_cmd,
  output logic [`PAGE_WORD_BITS-1:0] flash_buf_idx,
  input wire logic [15:0] flash_buf_word,
  input wire logic [14:0] flash_rd_addr,
  output logic [15:0] flash_rd_data
);
  import seq_pkg::*;
  logic [15:0] mem [0:32767];
  logic run;
  int step;

  initial begin
    foreach (mem[i]) begin
      mem[i] = `ERASED_WORD;
    end
  end

  assign flash_rd_data = mem[flash_rd_addr];

  // Each slot index is held two cycles because the buffer answers one cycle late.
  // The page is read live from the command, so a sequencer that failed to latch it shows up.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run <= 1'b0;
      step <= 0;
      flash_buf_idx <= '0;
    end else if (flash_cmd.req && !run) begin
      run <= 1'b1;
      step <= 0;
      flash_buf_idx <= '0;
      if (flash_cmd.erase) begin
        for (int i = 0; i < `PAGE_WORDS; i++) begin
          mem[{flash_cmd.page, i[5:0]}] = `ERASED_WORD;
        end
      end
    end else if (!flash_cmd.req) begin
      run <= 1'b0;
    end else if (!flash_cmd.erase && step < 128) begin
      step <= step + 1;
      if (step[0]) begin
        mem[{flash_cmd.page, flash_buf_idx}] &= flash_buf_word;
        flash_buf_idx <= flash_buf_idx + 6'h01;
      end
    end
  end
endmodule

// ===== tb/flash_self_programming_sequencer_tb.sv
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/100ps
module flash_self_programming_sequencer_tb;
  import seq_pkg::*;
  localparam int PROG = 300;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic in_boot = 1'b1;
  logic fuse = 1'b1;
  logic pll = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic ack;
  logic [31:0] rdat;
  logic halt;
  logic irq;
  logic [15:0] rvec;
  logic rvec_ok;
  flash_cmd_t fcmd;
  logic [5:0] bidx;
  logic [15:0] bword;
  logic [14:0] raddr;
  logic [15:0] rdata;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 83926;
  logic [15:0] exp_buf [64];
  bit loaded [64];
  logic [15:0] exp_mem [int];
  logic [31:0] q;
  logic [15:0] fw;

  flash_self_programming_sequencer #(.PROG_CYCLES(PROG)) dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .cpu_in_boot(in_boot), .core_halt(halt), .store_irq(irq), .reset_vector(rvec),
    .reset_vector_valid(rvec_ok), .boot_vector_fuse(fuse), .pll_locked(pll),
    .flash_cmd(fcmd), .flash_buf_idx(bidx), .flash_buf_word(bword),
    .flash_rd_addr(raddr), .flash_rd_data(rdata));

  flash_model far (
    .clk(clk), .sys_rst(sys_rst), .flash_cmd(fcmd), .flash_buf_idx(bidx),
    .flash_buf_word(bword), .flash_rd_addr(raddr), .flash_rd_data(rdata));

  // ****************************************************************
  // Clock, watchdog and reporting
  // ****************************************************************
  initial begin
    forever #5 clk = ~clk;
  end

  // The ceiling covers eight programming operations plus page read-back.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ****************************************************************
  // Bus and sequence tasks
  // ****************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("bus ack", 0, 1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rst_dut();
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (exp_buf[i]) begin
      exp_buf[i] = `ERASED_WORD;
      loaded[i] = 1'b0;
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] p);
    bus(1'b1, `ADDR_PTR, {16'h0, p});
    bus(1'b1, `ADDR_CTRL, {24'h0, c});
    bus(1'b1, `ADDR_STORE, 32'h0);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, `ADDR_CTRL, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    chk("store enable", q[0], 0);
  endtask

  task automatic load(input logic [5:0] slot);
    logic [15:0] d;
    d = 16'($random(seed));
    bus(1'b1, `ADDR_DATA, {16'h0, d});
    cmd(8'h01, {7'($random(seed)), slot, 1'($random(seed))});
    if (!loaded[slot]) exp_buf[slot] = d;
    loaded[slot] = 1'b1;
    wait_done();
  endtask

  task automatic reenable();
    cmd(8'h11, 16'h0);
    wait_done();
    chk("section busy", q[6], 0);
    foreach (exp_buf[i]) begin
      exp_buf[i] = `ERASED_WORD;
      loaded[i] = 1'b0;
    end
  endtask

  // Erase when er is set, page write otherwise; the pointer is scrambled mid-run.
  task automatic prog(input logic er, input logic [8:0] pg);
    int b;
    cmd(er ? 8'h03 : 8'h05, {pg, 7'($random(seed))});
    @(negedge clk);
    chk("halt", halt, pg >= `HALTING_SECTION_FIRST_PAGE);
    chk("flash cmd", {fcmd.req, fcmd.erase, fcmd.page}, {1'b1, er, pg});
    bus(1'b1, `ADDR_PTR, $random(seed));
    bus(1'b0, `ADDR_STAT, 32'h0);
    chk("status op", q[3:2], {pg >= `HALTING_SECTION_FIRST_PAGE, 1'b1});
    bus(1'b0, `ADDR_CTRL, 32'h0);
    chk("section busy", q[6], pg < `HALTING_SECTION_FIRST_PAGE);
    wait_done();
    @(negedge clk);
    chk("halt end", halt, 0);
    for (int i = 0; i < 64; i++) begin
      b = pg * 64 + i;
      if (er) exp_mem[b] = `ERASED_WORD;
      else exp_mem[b] = (exp_mem.exists(b) ? exp_mem[b] : 16'hffff) & exp_buf[i];
    end
    if (!er) begin
      foreach (exp_buf[i]) begin
        exp_buf[i] = `ERASED_WORD;
        loaded[i] = 1'b0;
      end
    end
  endtask

  task automatic check_page(input logic [8:0] pg);
    int b;
    for (int i = 0; i < 64; i++) begin
      b = pg * 64 + i;
      for (int h = 0; h < 2; h++) begin
        bus(1'b1, `ADDR_PTR, {16'h0, pg, i[5:0], h[0]});
        bus(1'b1, `ADDR_LOAD, 32'h0);
        @(posedge clk);
        bus(1'b0, `ADDR_LOAD, 32'h0);
        fw[h*8 +: 8] = q[7:0];
      end
      chk("flash word", fw, exp_mem.exists(b) ? exp_mem[b] : 16'hffff);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int f = 1; f >= 0; f--) begin
      fuse <= f[0];
      pll <= f[0];
      rst_dut();
      for (int n = 0; n < 20 && rvec_ok !== 1'b1; n++) @(posedge clk);
      chk("reset vector", rvec, f ? `APP_RESET_ADDR : `BOOT_RESET_ADDR);
      chk("vector valid", rvec_ok, 1);
      bus(1'b1, `ADDR_STAT, 32'h0);
      bus(1'b0, `ADDR_STAT, 32'h0);
      chk("status vector", q[31:16], f ? `APP_RESET_ADDR : `BOOT_RESET_ADDR);
      chk("pll lock", q[0], f);
    end
    // Programming starts only once the PLL reports lock.
    pll <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, `ADDR_STAT, 32'h0);
    chk("pll lock", q[0], 1);
    // Pages from the boot reset address up are never touched, so the loader stays intact.
    // Fill before erase, out of order, with one slot written twice.
    load(6'd7);
    load(6'd0);
    load(6'd63);
    load(6'd7);
    load(6'd31);
    prog(1'b1, 9'h1c0);
    prog(1'b0, 9'h1c0);
    check_page(9'h1c0);
    // Fill after erase on a readable-section page.
    prog(1'b1, 9'h003);
    load(6'd2);
    load(6'd1);
    prog(1'b0, 9'h003);
    reenable();
    check_page(9'h003);
    // Re-enable and reset both empty the buffer.
    load(6'd4);
    reenable();
    prog(1'b1, 9'h005);
    prog(1'b0, 9'h005);
    load(6'd9);
    rst_dut();
    prog(1'b1, 9'h005);
    prog(1'b0, 9'h005);
    reenable();
    check_page(9'h005);
    // Store too late after the control write.
    bus(1'b1, `ADDR_CTRL, 32'h03);
    repeat (8) @(posedge clk);
    bus(1'b0, `ADDR_CTRL, 32'h0);
    chk("ctrl cleared", q[5:0], 0);
    bus(1'b1, `ADDR_STORE, 32'h0);
    @(negedge clk);
    chk("late store", fcmd.req, 0);
    // A lock-bit pattern is refused and leaves the command bits clear.
    bus(1'b1, `ADDR_CTRL, 32'h09);
    bus(1'b0, `ADDR_CTRL, 32'h0);
    chk("lock pattern", q[5:0], 0);
    // Store from outside the boot section.
    in_boot <= 1'b0;
    cmd(8'h03, 16'h0300);
    @(negedge clk);
    chk("app store", fcmd.req, 0);
    in_boot <= 1'b1;
    repeat (8) @(posedge clk);
    // Interrupt stands while store enable is clear.
    bus(1'b1, `ADDR_CTRL, 32'h80);
    @(negedge clk);
    chk("irq idle", irq, 1);
    bus(1'b1, `ADDR_DATA, 32'h1234);
    bus(1'b1, `ADDR_PTR, 32'h0);
    bus(1'b1, `ADDR_CTRL, 32'h81);
    @(negedge clk);
    chk("irq busy", irq, 0);
    bus(1'b1, `ADDR_STORE, 32'h0);
    wait_done();
    @(negedge clk);
    chk("irq done", irq, 1);
    finish_test();
  end
endmodule
